// ---- core/tzc_map.vh ----
// Purpose: Constants for the thermal zone charge configuration register block
// Assumes: Byte-wide register addresses seen over the two-wire serial port
// Notes:   Thresholds are in hundredths of a percent of the sense ratio
`ifndef TZC_MAP_VH
`define TZC_MAP_VH

`define TZC_ADDR_FAULT      8'h09
`define TZC_ADDR_PART       8'h0B
`define TZC_ADDR_ZONE       8'h0C

`define TZC_ZONE_RESET      8'h75
`define TZC_PART_RESET      8'h00

`define TZC_COOL_I_HI       7
`define TZC_COOL_I_LO       6
`define TZC_WARM_I_HI       5
`define TZC_WARM_I_LO       4
`define TZC_COOL_T_HI       3
`define TZC_COOL_T_LO       2
`define TZC_WARM_T_HI       1
`define TZC_WARM_T_LO       0
`define TZC_PART_RST_BIT    7
`define TZC_FAULT_WD_BIT    7

`define TZC_ISET_NONE       2'h0
`define TZC_ISET_FIFTH      2'h1
`define TZC_ISET_HALF       2'h2
`define TZC_ISET_FULL       2'h3

`define TZC_PCT_NONE        7'h00
`define TZC_PCT_FIFTH       7'h14
`define TZC_PCT_HALF        7'h32
`define TZC_PCT_FULL        7'h64

`define TZC_COOL_T0         13'h1BA3
`define TZC_COOL_T1         13'h1AA9
`define TZC_COOL_T2         13'h197D
`define TZC_COOL_T3         13'h1851
`define TZC_WARM_T0         13'h12D9
`define TZC_WARM_T1         13'h117B
`define TZC_WARM_T2         13'h0FEB
`define TZC_WARM_T3         13'h0EBF

`endif

// ---- core/tzc_zone_decode.v ----
// Purpose: Turns the stored zone byte into current fractions and thresholds
// Assumes: Outputs feed the analog loops; values registered for clean timing
// Notes:   Threshold values are hundredths of a percent of the sense ratio
`timescale 1ns/10ps
`include "tzc_map.vh"

module tzc_zone_decode
(
  input  wire        mclk_in,
  input  wire        rst_n_in,
  input  wire        ce_in,
  input  wire [7:0]  zone_in,
  output reg  [6:0]  cool_zone_current_pct_out,
  output reg  [6:0]  warm_zone_current_pct_out,
  output reg         cool_timer_double_out,
  output reg         warm_timer_double_out,
  output reg  [12:0] cool_threshold_out,
  output reg  [12:0] warm_threshold_out
);

  function [6:0] iset_pct;
    input [1:0] code;
    begin
      case (code)
        `TZC_ISET_NONE:  iset_pct = `TZC_PCT_NONE;
        `TZC_ISET_FIFTH: iset_pct = `TZC_PCT_FIFTH;
        `TZC_ISET_HALF:  iset_pct = `TZC_PCT_HALF;
        default:         iset_pct = `TZC_PCT_FULL;
      endcase
    end
  endfunction

  wire [1:0] cool_iset = zone_in[`TZC_COOL_I_HI:`TZC_COOL_I_LO];
  wire [1:0] warm_iset = zone_in[`TZC_WARM_I_HI:`TZC_WARM_I_LO];

  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cool_zone_current_pct_out <= `TZC_PCT_FIFTH;
      warm_zone_current_pct_out <= `TZC_PCT_FULL;
      cool_timer_double_out     <= 1'b1;
      warm_timer_double_out     <= 1'b0;
      cool_threshold_out        <= `TZC_COOL_T1;
      warm_threshold_out        <= `TZC_WARM_T1;
    end
    else if (ce_in)
    begin
      cool_zone_current_pct_out <= iset_pct(cool_iset);
      warm_zone_current_pct_out <= iset_pct(warm_iset);
      cool_timer_double_out     <= (cool_iset != `TZC_ISET_FULL);
      warm_timer_double_out     <= (warm_iset != `TZC_ISET_FULL);
      case (zone_in[`TZC_COOL_T_HI:`TZC_COOL_T_LO])
        2'h0:    cool_threshold_out <= `TZC_COOL_T0;
        2'h1:    cool_threshold_out <= `TZC_COOL_T1;
        2'h2:    cool_threshold_out <= `TZC_COOL_T2;
        default: cool_threshold_out <= `TZC_COOL_T3;
      endcase
      case (zone_in[`TZC_WARM_T_HI:`TZC_WARM_T_LO])
        2'h0:    warm_threshold_out <= `TZC_WARM_T0;
        2'h1:    warm_threshold_out <= `TZC_WARM_T1;
        2'h2:    warm_threshold_out <= `TZC_WARM_T2;
        default: warm_threshold_out <= `TZC_WARM_T3;
      endcase
    end
  end

endmodule // tzc_zone_decode

// ---- core/tzc_top.v ----
// Purpose: Serial-port target holding the thermal zone charge configuration byte
// Assumes: scl_in and sda_in are synchronous to mclk_in and slow against it
// Notes:   Open-drain data pin; only pull-low is ever driven
`timescale 1ns/10ps
`include "tzc_map.vh"

module tzc_top
#(
  parameter [6:0] DEV_ADDR  = 7'h2A,
  // Arbitrary part code, low bits of the part register
  parameter [6:0] PART_CODE = 7'h05
)
(
  input  wire        mclk_in,
  input  wire        rst_n_in,
  input  wire        ce_in,
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe_out,
  input  wire        watchdog_expire_in,
  output wire        host_mode_out,
  output wire        safety_timer_reset_out,
  output wire [7:0]  zone_cfg_out,
  output wire [6:0]  cool_zone_current_pct_out,
  output wire [6:0]  warm_zone_current_pct_out,
  output wire        cool_timer_double_out,
  output wire        warm_timer_double_out,
  output wire [12:0] cool_threshold_out,
  output wire [12:0] warm_threshold_out
);

  localparam [3:0] ST_IDLE  = 4'h0;
  localparam [3:0] ST_ADDR  = 4'h1;
  localparam [3:0] ST_ACKA  = 4'h2;
  localparam [3:0] ST_PTR   = 4'h3;
  localparam [3:0] ST_ACKW  = 4'h4;
  localparam [3:0] ST_DATA  = 4'h5;
  localparam [3:0] ST_READ  = 4'h6;
  localparam [3:0] ST_RACK  = 4'h7;

  reg  [3:0] st_reg;
  reg  [3:0] cnt_reg;
  reg  [7:0] shift_reg;
  reg  [7:0] tx_reg;
  reg  [7:0] ptr_reg;
  reg        rw_reg;
  reg        scl_q_reg;
  reg        sda_q_reg;
  reg        sda_oe_reg;
  reg  [7:0] zone_reg;
  reg        rst_pend_reg;
  reg        wd_fault_reg;
  reg        host_mode_reg;
  reg        tmr_rst_reg;

  wire start_det = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
  wire stop_det  = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
  wire scl_rise  = scl_in & ~scl_q_reg;
  wire scl_fall  = ~scl_in & scl_q_reg;

  // Read-side view of the map; unmapped addresses answer zero
  function [7:0] reg_read;
    input [7:0] addr;
    input [7:0] zone;
    input       pend;
    input       wdf;
    begin
      case (addr)
        `TZC_ADDR_ZONE:  reg_read = zone;
        `TZC_ADDR_PART:  reg_read = {pend, PART_CODE};
        `TZC_ADDR_FAULT: reg_read = {wdf, 7'h00};
        default:         reg_read = 8'h00;
      endcase
    end
  endfunction

  wire [7:0] rd_byte = reg_read(ptr_reg, zone_reg, rst_pend_reg, wd_fault_reg);

  // Fault flag clears when its byte is loaded for sending
  wire rd_load   = ((st_reg == ST_ACKA) & rw_reg & scl_fall) |
                   ((st_reg == ST_RACK) & scl_fall);
  wire fault_clr = rd_load & (ptr_reg == `TZC_ADDR_FAULT);
  wire wr_byte   = (st_reg == ST_DATA) & scl_fall & (cnt_reg == 4'h8) & ~start_det & ~stop_det;

  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_reg     <= ST_IDLE;
      cnt_reg    <= 4'h0;
      shift_reg  <= 8'h00;
      tx_reg     <= 8'h00;
      ptr_reg    <= 8'h00;
      rw_reg     <= 1'b0;
      scl_q_reg  <= 1'b1;
      sda_q_reg  <= 1'b1;
      sda_oe_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      scl_q_reg <= scl_in;
      sda_q_reg <= sda_in;
      if (start_det)
      begin
        st_reg     <= ST_ADDR;
        cnt_reg    <= 4'h0;
        sda_oe_reg <= 1'b0;
      end
      else if (stop_det)
      begin
        st_reg     <= ST_IDLE;
        sda_oe_reg <= 1'b0;
      end
      else
      begin
        case (st_reg)
          ST_ADDR, ST_PTR, ST_DATA:
          begin
            if (scl_rise && cnt_reg != 4'h8)
            begin
              shift_reg <= {shift_reg[6:0], sda_in};
              cnt_reg   <= cnt_reg + 4'h1;
            end
            else if (scl_fall && cnt_reg == 4'h8)
            begin
              cnt_reg <= 4'h0;
              if (st_reg == ST_ADDR)
              begin
                if (shift_reg[7:1] == DEV_ADDR)
                begin
                  rw_reg     <= shift_reg[0];
                  sda_oe_reg <= 1'b1;
                  st_reg     <= ST_ACKA;
                end
                else
                  st_reg <= ST_IDLE;
              end
              else
              begin
                if (st_reg == ST_PTR)
                  ptr_reg <= shift_reg;
                else
                  ptr_reg <= ptr_reg + 8'h01;
                sda_oe_reg <= 1'b1;
                st_reg     <= ST_ACKW;
              end
            end
          end
          ST_ACKA:
          begin
            if (scl_fall)
            begin
              cnt_reg <= 4'h0;
              if (rw_reg)
              begin
                tx_reg     <= rd_byte;
                sda_oe_reg <= ~rd_byte[7];
                st_reg     <= ST_READ;
              end
              else
              begin
                sda_oe_reg <= 1'b0;
                st_reg     <= ST_PTR;
              end
            end
          end
          ST_ACKW:
          begin
            if (scl_fall)
            begin
              sda_oe_reg <= 1'b0;
              st_reg     <= ST_DATA;
            end
          end
          ST_READ:
          begin
            if (scl_fall)
            begin
              if (cnt_reg == 4'h7)
              begin
                sda_oe_reg <= 1'b0;
                ptr_reg    <= ptr_reg + 8'h01;
                st_reg     <= ST_RACK;
              end
              else
              begin
                tx_reg     <= {tx_reg[6:0], 1'b0};
                sda_oe_reg <= ~tx_reg[6];
                cnt_reg    <= cnt_reg + 4'h1;
              end
            end
          end
          ST_RACK:
          begin
            if (scl_rise && sda_in)
              st_reg <= ST_IDLE;
            else if (scl_fall)
            begin
              cnt_reg    <= 4'h0;
              tx_reg     <= rd_byte;
              sda_oe_reg <= ~rd_byte[7];
              st_reg     <= ST_READ;
            end
          end
          default:
          begin
            st_reg     <= ST_IDLE;
            sda_oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // Defaults win over a host write landing in the same cycle
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      zone_reg      <= `TZC_ZONE_RESET;
      rst_pend_reg  <= 1'b0;
      wd_fault_reg  <= 1'b0;
      host_mode_reg <= 1'b0;
      tmr_rst_reg   <= 1'b0;
    end
    else if (ce_in)
    begin
      tmr_rst_reg <= 1'b0;
      if (watchdog_expire_in)
        wd_fault_reg <= 1'b1;
      else if (fault_clr)
        wd_fault_reg <= 1'b0;
      if (watchdog_expire_in)
        host_mode_reg <= 1'b0;
      else if (wr_byte)
        host_mode_reg <= 1'b1;
      // defaults on watchdog or soft reset
      if (watchdog_expire_in || rst_pend_reg)
        zone_reg <= `TZC_ZONE_RESET;
      else if (wr_byte && ptr_reg == `TZC_ADDR_ZONE)
        zone_reg <= shift_reg;
      if (rst_pend_reg)
      begin
        rst_pend_reg <= 1'b0;
        tmr_rst_reg  <= 1'b1;
      end
      else if (wr_byte && ptr_reg == `TZC_ADDR_PART)
        rst_pend_reg <= shift_reg[`TZC_PART_RST_BIT];
    end
  end

  assign sda_out                = 1'b0;
  assign sda_oe_out             = sda_oe_reg;
  assign host_mode_out          = host_mode_reg;
  assign safety_timer_reset_out = tmr_rst_reg;
  assign zone_cfg_out           = zone_reg;

  tzc_zone_decode u_decode
  (
    .mclk_in                   (mclk_in),
    .rst_n_in                  (rst_n_in),
    .ce_in                     (ce_in),
    .zone_in                   (zone_reg),
    .cool_zone_current_pct_out (cool_zone_current_pct_out),
    .warm_zone_current_pct_out (warm_zone_current_pct_out),
    .cool_timer_double_out     (cool_timer_double_out),
    .warm_timer_double_out     (warm_timer_double_out),
    .cool_threshold_out        (cool_threshold_out),
    .warm_threshold_out        (warm_threshold_out)
  );

endmodule // tzc_top

// ---- testbench/tzc_chk.sv ----
// Purpose: Port-level checks for the thermal zone charge configuration block
// Assumes: One clock domain; serial clock slow against mclk_in
// Notes:   Decode outputs trail the stored byte by one cycle
`timescale 1ns/10ps
module tzc_chk
(
  input wire logic        mclk_in,
  input wire logic        rst_n_in,
  input wire logic        ce_in,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_oe_out,
  input wire logic        watchdog_expire_in,
  input wire logic        host_mode_out,
  input wire logic        safety_timer_reset_out,
  input wire logic [7:0]  zone_cfg_out,
  input wire logic [6:0]  cool_zone_current_pct_out,
  input wire logic [6:0]  warm_zone_current_pct_out,
  input wire logic        cool_timer_double_out,
  input wire logic        warm_timer_double_out,
  input wire logic [12:0] cool_threshold_out,
  input wire logic [12:0] warm_threshold_out
);
  localparam logic [6:0]  PCT [4] = '{7'h00, 7'h14, 7'h32, 7'h64};
  localparam logic [12:0] CT [4]  = '{13'h1BA3, 13'h1AA9, 13'h197D, 13'h1851};
  localparam logic [12:0] WT [4]  = '{13'h12D9, 13'h117B, 13'h0FEB, 13'h0EBF};

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  chk_wd_defaults: assert property (watchdog_expire_in && ce_in |=>
    zone_cfg_out == 8'h75 && !host_mode_out) else $error("watchdog left settings");
  chk_cool_pct: assert property (ce_in |=>
    cool_zone_current_pct_out == PCT[$past(zone_cfg_out[7:6])]) else $error("cool current");
  chk_warm_pct: assert property (ce_in |=>
    warm_zone_current_pct_out == PCT[$past(zone_cfg_out[5:4])]) else $error("warm current");
  chk_timer_double: assert property (ce_in |=>
    {cool_timer_double_out, warm_timer_double_out} ==
    {$past(zone_cfg_out[7:6]) != 2'h3, $past(zone_cfg_out[5:4]) != 2'h3})
    else $error("timer double flag");
  chk_cool_thresh: assert property (ce_in |=>
    cool_threshold_out == CT[$past(zone_cfg_out[3:2])]) else $error("cool threshold");
  chk_warm_thresh: assert property (ce_in |=>
    warm_threshold_out == WT[$past(zone_cfg_out[1:0])]) else $error("warm threshold");
  chk_soft_pulse: assert property (safety_timer_reset_out |->
    zone_cfg_out == 8'h75 ##1 !safety_timer_reset_out) else $error("soft reset pulse");
  // Start or stop from the host may legally drop the answer with the clock high
  chk_sda_held: assert property (scl_in && $past(scl_in) &&
    $past(sda_in, 2) == $past(sda_in) |-> $stable(sda_oe_out))
    else $error("data line moved with clock high");
  chk_ce_freeze: assert property (!ce_in |=> $stable({zone_cfg_out, host_mode_out,
    sda_oe_out, safety_timer_reset_out, cool_threshold_out}))
    else $error("state moved with enable low");

  cover property (watchdog_expire_in);
  cover property (safety_timer_reset_out);
  cover property ($rose(host_mode_out));
endmodule // tzc_chk

// ---- testbench/tzc_host.sv ----
// Purpose: Serial host model driving the clock and pulling the data line low
// Assumes: Data line has a pull-up; eight mclk cycles per bit
// Notes:   Changes its lines only on the falling edge of mclk_in
`timescale 1ns/10ps
module tzc_host #(parameter logic [6:0] DEV = 7'h2A)
(
  input  wire logic mclk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic bitx(input logic b, output logic r);
    sda_low_out = ~b;
    hw(2);
    scl_out = 1'b1;
    hw(4);
    r = sda_in;
    scl_out = 1'b0;
    hw(2);
  endtask
  task automatic start();
    sda_low_out = 1'b0;
    hw(2);
    scl_out = 1'b1;
    hw(4);
    sda_low_out = 1'b1;
    hw(4);
    scl_out = 1'b0;
    hw(2);
  endtask
  task automatic stop();
    sda_low_out = 1'b1;
    hw(2);
    scl_out = 1'b1;
    hw(4);
    sda_low_out = 1'b0;
    hw(4);
  endtask
  task automatic byte_x(input logic [7:0] d, input logic ab, output logic [7:0] q,
                        output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(ab, r);
    ack = ~r;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] a, d, output logic ok);
    logic [7:0] q;
    logic k1, k2, k3;
    start();
    byte_x({dev, 1'b0}, 1'b1, q, k1);
    byte_x(a, 1'b1, q, k2);
    byte_x(d, 1'b1, q, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    logic k;
    start();
    byte_x({DEV, 1'b0}, 1'b1, q, k);
    byte_x(a, 1'b1, q, k);
    start();
    byte_x({DEV, 1'b1}, 1'b1, q, k);
    byte_x(8'hFF, 1'b1, q, k);
    stop();
  endtask
endmodule // tzc_host

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench for the zone charge configuration register
// Assumes: Clock enable dropped in one scenario only; host model does all bus traffic
// Notes:   Field expected values come from the bench tables below; other checks use literals
`timescale 1ns/10ps
module testbench;
  logic mclk = 1'b0, rst_n = 1'b0, wd = 1'b0, scl, sda_low, oe, sto, hm, cd, wdb, ok;
  logic ce = 1'b1, sda_drv;
  logic [7:0]  zone, v;
  logic [6:0]  cp, wp;
  logic [12:0] ct, wt;
  int failures = 0, n_compared = 0, cyc = 0, pulses = 0;
  wire sda = ~(oe | sda_low);
  logic [6:0]  pct [4] = '{7'h00, 7'h14, 7'h32, 7'h64};
  logic [12:0] cool_t [4] = '{13'h1BA3, 13'h1AA9, 13'h197D, 13'h1851};
  logic [12:0] warm_t [4] = '{13'h12D9, 13'h117B, 13'h0FEB, 13'h0EBF};

  tzc_top tzc_top_inst (.mclk_in(mclk), .rst_n_in(rst_n), .ce_in(ce), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_drv), .sda_oe_out(oe), .watchdog_expire_in(wd), .host_mode_out(hm),
    .safety_timer_reset_out(sto), .zone_cfg_out(zone), .cool_zone_current_pct_out(cp),
    .warm_zone_current_pct_out(wp), .cool_timer_double_out(cd), .warm_timer_double_out(wdb),
    .cool_threshold_out(ct), .warm_threshold_out(wt));
  tzc_host tzc_host_inst (.mclk_in(mclk), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));

  initial
    forever #5 mclk = ~mclk;

  task automatic check(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    pulses <= pulses + sto;
    if (cyc == 30000)
    begin
      failures++;
      complete_run();
    end
  end

  task automatic t_reset();
    check(zone, 8'h75);
    check({cp, wp}, {7'h14, 7'h64});
    check({cd, wdb, hm}, 3'h4);
    check({ct, wt}, {13'h1AA9, 13'h117B});
    check(sda_drv, 1'b0);
    tzc_host_inst.rd(8'h0C, v);
    check(v, 8'h75);
  endtask
  // Fields rotated so each takes every code and a swap shows
  task automatic t_fields();
    logic [1:0] f [4];
    for (int c = 0; c < 4; c++)
    begin
      for (int j = 0; j < 4; j++)
        f[j] = 2'(c + j);
      tzc_host_inst.wr(7'h2A, 8'h0C, {f[0], f[1], f[2], f[3]}, ok);
      check({ok, hm}, 2'h3);
      check({cp, wp}, {pct[f[0]], pct[f[1]]});
      check({cd, wdb}, {f[0] != 2'h3, f[1] != 2'h3});
      check({ct, wt}, {cool_t[f[2]], warm_t[f[3]]});
      tzc_host_inst.rd(8'h0C, v);
      check(v, {f[0], f[1], f[2], f[3]});
    end
  endtask
  task automatic t_refuse();
    logic [7:0] was;
    was = zone;
    tzc_host_inst.wr(7'h2B, 8'h0C, 8'h00, ok);
    check({ok, zone}, {1'b0, was});
    tzc_host_inst.rd(8'h0D, v);
    check(v, 8'h00);
  endtask
  task automatic t_soft();
    int p0;
    tzc_host_inst.wr(7'h2A, 8'h0C, 8'h00, ok);
    p0 = pulses;
    tzc_host_inst.wr(7'h2A, 8'h0B, 8'h80, ok);
    check({zone, 8'(pulses - p0)}, 16'h7501);
    tzc_host_inst.rd(8'h0B, v);
    check(v[7], 1'b0);
  endtask
  task automatic t_wd();
    tzc_host_inst.wr(7'h2A, 8'h0C, 8'hC3, ok);
    @(negedge mclk);
    wd = 1'b1;
    @(negedge mclk);
    wd = 1'b0;
    check({zone, hm}, {8'h75, 1'b0});
    tzc_host_inst.rd(8'h09, v);
    check(v[7], 1'b1);
  endtask
  // Enable low must hold every register, even against a watchdog pulse
  task automatic t_freeze();
    tzc_host_inst.wr(7'h2A, 8'h0C, 8'h5A, ok);
    @(negedge mclk);
    ce = 1'b0;
    wd = 1'b1;
    repeat (3) @(negedge mclk);
    wd = 1'b0;
    @(negedge mclk);
    ce = 1'b1;
    repeat (2) @(negedge mclk);
    check({zone, hm, cp, wp}, {8'h5A, 1'b1, 7'h14, 7'h14});
    tzc_host_inst.rd(8'h09, v);
    check(v[7], 1'b0);
  endtask

  initial
  begin
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    t_reset();
    t_fields();
    t_refuse();
    t_soft();
    t_wd();
    t_freeze();
    complete_run();
  end
endmodule // testbench

bind tzc_top tzc_chk tzc_chk_inst (.mclk_in, .rst_n_in, .ce_in, .scl_in, .sda_in, .sda_oe_out,
  .watchdog_expire_in, .host_mode_out, .safety_timer_reset_out, .zone_cfg_out,
  .cool_zone_current_pct_out, .warm_zone_current_pct_out, .cool_timer_double_out,
  .warm_timer_double_out, .cool_threshold_out, .warm_threshold_out);
